// ===== core/lfs_regs.svh
`ifndef LFS_REGS_SVH
`define LFS_REGS_SVH

// Register indices; byte address is four times the index
`define LFS_ANA_IDX        14'h0422
`define LFS_LINK_IDX       14'h0423
`define LFS_IRQ_STAT_IDX   14'h0430
`define LFS_IRQ_EN_IDX     14'h0431
`define LFS_IRQ_CLR_IDX    14'h0432

// Analog fault status fields
`define LFS_ANA_SELFTEST_BIT   0
`define LFS_ANA_BALANCE_BIT    1

// Link fault status fields
`define LFS_LINK_FRAMING_BIT   0
`define LFS_LINK_CHECKSUM_BIT  1
`define LFS_LINK_SAT_BIT       2
`define LFS_LINK_TIMEOUT_BIT   3
`define LFS_LINK_RPLEN_BIT     4
`define LFS_LINK_TALLY_LSB     8
`define LFS_LINK_TALLY_MSB     15

// Interrupt status, enable and clear layout
`define LFS_IRQ_FRAMING_BIT    0
`define LFS_IRQ_CHECKSUM_BIT   1
`define LFS_IRQ_SAT_BIT        2
`define LFS_IRQ_TIMEOUT_BIT    3
`define LFS_IRQ_RPLEN_BIT      4
`define LFS_IRQ_BALANCE_BIT    5
`define LFS_IRQ_SELFTEST_BIT   6

// Reset values and limits
`define LFS_TALLY_RESET    8'h00
`define LFS_TALLY_MAX      8'hFF
`define LFS_TALLY_NEAR     8'hFE
`define LFS_FLAGS_RESET    7'h00

`endif

// ===== core/lfs_pkg.sv
package lfs_pkg;

	// Fault events for one clock cycle
	typedef struct packed {
		logic selftest;
		logic balance;
		logic rplen;
		logic timeout;
		logic checksum;
		logic framing;
	} lfs_evt_s;

	// Sticky link flags
	typedef struct packed {
		logic rplen;
		logic timeout;
		logic saturated;
		logic checksum;
		logic framing;
	} lfs_link_flags_s;

	typedef logic [6:0] lfs_irq_t;

endpackage : lfs_pkg

// ===== core/lfs_top.sv
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - Sticky balance fault, cleared by writing one
// - Sticky self-test fail flag, write-one clear, resets zero
// - Reserved bits read zero, ignore writes
// - Tally bits 15:8 counts frames with a framing or checksum error, one per frame
// - Tally saturates at 255, never wraps
// - Nonzero tally write clears; zero write ignored
// - Sticky reply length fault in bit 4
// - Sticky link timeout flag in bit 3
// - Sticky saturation flag when tally reaches max
// - Sticky checksum fault flag in bit 1
// - Sticky framing fault flag in bit 0
// - Tally and link flags zero after reset
`include "lfs_regs.svh"

module lfs_top
	import lfs_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [15:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        link_clk,
	input  wire logic        link_framing_err,
	input  wire logic        link_checksum_err,
	input  wire logic        link_rplen_err,
	input  wire logic        link_timeout_err,
	input  wire logic        balance_fault_evt,
	input  wire logic        selftest_fail_evt,
	output logic             irq
);

	localparam int SYNC_W = 5;

	////////////////////////////////////////////////////////////////////////////////
	// Link pin synchronisers and edge finding

	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic [SYNC_W-1:0] pins;
	logic              link_clk_prev_q;
	logic              link_rise;

	assign pins = {link_timeout_err, link_rplen_err, link_checksum_err, link_framing_err, link_clk};

	for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				sync1_q[i] <= 1'b0;
				sync2_q[i] <= 1'b0;
			end else begin
				sync1_q[i] <= pins[i];
				sync2_q[i] <= sync1_q[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link_clk_prev_q <= 1'b0;
		end else begin
			link_clk_prev_q <= sync2_q[0];
		end
	end

	// Error lines are sampled at the link clock rising edge; they share the same sync delay
	assign link_rise = sync2_q[0] & ~link_clk_prev_q;

	lfs_evt_s evt;
	always_comb begin
		evt          = '0;
		evt.framing  = link_rise & sync2_q[1];
		evt.checksum = link_rise & sync2_q[2];
		evt.rplen    = link_rise & sync2_q[3];
		evt.timeout  = link_rise & sync2_q[4];
		evt.balance  = balance_fault_evt;
		evt.selftest = selftest_fail_evt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone slave: ack one cycle after the request, write lands on the ack edge

	logic ack_q;
	logic req;
	logic wr_fire;
	logic hit_ana;
	logic hit_link;
	logic hit_stat;
	logic hit_en;
	logic hit_clr;

	assign req      = wb_cyc_i & wb_stb_i;
	assign wr_fire  = req & wb_we_i & ack_q;
	assign hit_ana  = wb_adr_i[15:2] == `LFS_ANA_IDX;
	assign hit_link = wb_adr_i[15:2] == `LFS_LINK_IDX;
	assign hit_stat = wb_adr_i[15:2] == `LFS_IRQ_STAT_IDX;
	assign hit_en   = wb_adr_i[15:2] == `LFS_IRQ_EN_IDX;
	assign hit_clr  = wb_adr_i[15:2] == `LFS_IRQ_CLR_IDX;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	assign wb_ack_o = ack_q;

	// Write-one-clear masks, honouring byte lanes
	logic [7:0] lo_w1c;
	logic       tally_wr_clear;
	assign lo_w1c         = (wr_fire && wb_sel_i[0]) ? wb_dat_i[7:0] : 8'h00;
	assign tally_wr_clear = wr_fire & hit_link & wb_sel_i[1] & (wb_dat_i[15:8] != 8'h00);

	////////////////////////////////////////////////////////////////////////////////
	// Analog fault flags

	logic balance_fault_flag_q;
	logic monitor_selftest_fail_flag_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			balance_fault_flag_q <= 1'b0;
		end else if (evt.balance) begin
			balance_fault_flag_q <= 1'b1;
		end else if (hit_ana && lo_w1c[`LFS_ANA_BALANCE_BIT]) begin
			balance_fault_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			monitor_selftest_fail_flag_q <= 1'b0;
		end else if (evt.selftest) begin
			monitor_selftest_fail_flag_q <= 1'b1;
		end else if (hit_ana && lo_w1c[`LFS_ANA_SELFTEST_BIT]) begin
			monitor_selftest_fail_flag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Error tally and link flags

	logic [7:0]      link_error_tally_q;
	logic            tally_inc;
	logic            tally_hit_max;
	lfs_link_flags_s link_flags_q;
	lfs_link_flags_s link_set;
	lfs_link_flags_s link_clr;

	assign tally_inc     = evt.framing | evt.checksum;
	assign tally_hit_max = tally_inc & ((tally_wr_clear ? `LFS_TALLY_RESET : link_error_tally_q) == `LFS_TALLY_NEAR);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link_error_tally_q <= `LFS_TALLY_RESET;
		end else if (tally_wr_clear) begin
			link_error_tally_q <= tally_inc ? 8'h01 : `LFS_TALLY_RESET;
		end else if (tally_inc && link_error_tally_q != `LFS_TALLY_MAX) begin
			link_error_tally_q <= link_error_tally_q + 8'h01;
		end
	end

	always_comb begin
		link_set           = '0;
		link_set.framing   = evt.framing;
		link_set.checksum  = evt.checksum;
		link_set.saturated = tally_hit_max;
		link_set.timeout   = evt.timeout;
		link_set.rplen     = evt.rplen;
		link_clr           = hit_link ? lfs_link_flags_s'(lo_w1c[4:0]) : '0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link_flags_q <= lfs_link_flags_s'(5'h00);
		end else begin
			link_flags_q <= link_set | (link_flags_q & ~link_clr);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status, enable, clear

	lfs_irq_t irq_stat_q;
	lfs_irq_t irq_en_q;
	lfs_irq_t irq_src;
	lfs_irq_t irq_clr;
	logic     irq_q;

	assign irq_src = {evt.selftest, evt.balance, evt.rplen, evt.timeout, tally_hit_max, evt.checksum, evt.framing};
	assign irq_clr = hit_clr ? lo_w1c[6:0] : `LFS_FLAGS_RESET;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_q <= `LFS_FLAGS_RESET;
		end else begin
			irq_stat_q <= irq_src | (irq_stat_q & ~irq_clr);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_en_q <= `LFS_FLAGS_RESET;
		end else if (wr_fire && hit_en && wb_sel_i[0]) begin
			irq_en_q <= wb_dat_i[6:0];
		end
	end

	// Registered, so it follows the status by one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_en_q);
		end
	end

	assign irq = irq_q;

	////////////////////////////////////////////////////////////////////////////////
	// Read data, captured in the request cycle

	logic [31:0] rd_d;
	logic [31:0] rd_q;

	always_comb begin
		rd_d = 32'h0000_0000;
		if (hit_ana) begin
			rd_d[`LFS_ANA_BALANCE_BIT]  = balance_fault_flag_q;
			rd_d[`LFS_ANA_SELFTEST_BIT] = monitor_selftest_fail_flag_q;
		end else if (hit_link) begin
			rd_d[`LFS_LINK_TALLY_MSB:`LFS_LINK_TALLY_LSB] = link_error_tally_q;
			rd_d[4:0] = link_flags_q;
		end else if (hit_stat) begin
			rd_d[6:0] = irq_stat_q;
		end else if (hit_en) begin
			rd_d[6:0] = irq_en_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_q <= 32'h0000_0000;
		end else if (req && !ack_q && !wb_we_i) begin
			rd_q <= rd_d;
		end
	end

	assign wb_dat_o = rd_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_balance_sticky;
		balance_fault_flag_q && !(hit_ana && lo_w1c[`LFS_ANA_BALANCE_BIT]) |=> balance_fault_flag_q;
	endproperty
	a_balance_sticky: assert property (p_balance_sticky) else $error("balance flag lost");

	property p_selftest_set;
		evt.selftest |=> monitor_selftest_fail_flag_q;
	endproperty
	a_selftest_set: assert property (p_selftest_set) else $error("self-test flag not set");

	property p_reserved_zero;
		ack_q && !wb_we_i && $past(hit_link) |-> wb_dat_o[7:5] == 3'h0 && wb_dat_o[31:16] == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

	property p_tally_count;
		tally_inc && !tally_wr_clear && link_error_tally_q < `LFS_TALLY_MAX
			|=> link_error_tally_q == $past(link_error_tally_q) + 8'h01;
	endproperty
	a_tally_count: assert property (p_tally_count) else $error("tally missed an error");

	property p_tally_saturate;
		link_error_tally_q == `LFS_TALLY_MAX && !tally_wr_clear |=> link_error_tally_q == `LFS_TALLY_MAX;
	endproperty
	a_tally_saturate: assert property (p_tally_saturate) else $error("tally wrapped");

	property p_tally_clear;
		tally_wr_clear && !tally_inc |=> link_error_tally_q == `LFS_TALLY_RESET;
	endproperty
	a_tally_clear: assert property (p_tally_clear) else $error("tally not cleared");

	property p_sat_flag;
		tally_inc && !tally_wr_clear && link_error_tally_q == `LFS_TALLY_NEAR
			|=> link_flags_q.saturated && link_error_tally_q == `LFS_TALLY_MAX;
	endproperty
	a_sat_flag: assert property (p_sat_flag) else $error("saturation flag not set");

	property p_framing_set;
		evt.framing |=> link_flags_q.framing ##1 1'b1;
	endproperty
	a_framing_set: assert property (p_framing_set) else $error("framing flag not set");

	property p_link_set_wins;
		(evt.timeout || evt.rplen || evt.checksum) && hit_link && wr_fire
			|=> (link_flags_q.timeout || !$past(evt.timeout)) && (link_flags_q.rplen || !$past(evt.rplen))
				&& (link_flags_q.checksum || !$past(evt.checksum));
	endproperty
	a_link_set_wins: assert property (p_link_set_wins) else $error("clear beat a set");

	property p_ack_pulse;
		ack_q |=> !ack_q;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

	property p_irq_follow;
		|(irq_stat_q & irq_en_q) |=> irq;
	endproperty
	a_irq_follow: assert property (p_irq_follow) else $error("interrupt not raised");

endmodule : lfs_top

// ===== verif/lfs_link_model.sv
`timescale 1ns/100ps
module lfs_link_model (
	output logic link_clk,
	output logic framing,
	output logic checksum,
	output logic rplen,
	output logic timeout
);
	initial begin
		link_clk = 1'b0;
		{timeout, rplen, checksum, framing} = 4'h0;
	end

	// One link clock pulse per frame, 64 ns period; the clock idles low between frames.
	// Every change lands 1 ns past a system clock edge so no pin moves on a sampling edge.
	task automatic frame(input logic [3:0] e);
		#1;
		{timeout, rplen, checksum, framing} = e;
		#16;
		link_clk = 1'b1;
		#32;
		link_clk = 1'b0;
		// Stale levels are inverted so that nothing passes on a leftover value
		{timeout, rplen, checksum, framing} = ~e;
		#15;
	endtask : frame
endmodule : lfs_link_model

// ===== verif/test_lfs_top.sv
`timescale 1ns/100ps
module test_lfs_top
	import lfs_pkg::*;
;
	localparam logic [15:0] adr_ana = 16'h1088;
	localparam logic [15:0] adr_lnk = 16'h108c;
	localparam logic [15:0] adr_ist = 16'h10c0;
	localparam logic [15:0] adr_ien = 16'h10c4;
	localparam logic [15:0] adr_icl = 16'h10c8;
	localparam logic [15:0] adr_nul = 16'h0010;

	logic        clk, rst_n, cyc, stb, we, bal, st;
	logic [15:0] adr;
	logic [3:0]  sel;
	logic [31:0] dat, m;
	logic [3:0]  k;
	wire  [31:0] rdat;
	wire         ack, irq, lclk, fr, cs, rl, to;
	logic [31:0] expq[$];
	int          n_mismatch, cmp_count;

	lfs_top i_lfs_top (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.link_clk(lclk), .link_framing_err(fr), .link_checksum_err(cs), .link_rplen_err(rl),
		.link_timeout_err(to), .balance_fault_evt(bal), .selftest_fail_evt(st), .irq(irq));
	lfs_link_model i_lfs_link_model (.link_clk(lclk), .framing(fr), .checksum(cs), .rplen(rl), .timeout(to));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic stop_test;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic wb(input logic w, input logic [15:0] a, input logic [3:0] s, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) chk("ack", 32'h0000_0001, 32'h0000_0000);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		expq.push_back(e);
		wb(1'b0, a, 4'hf, 32'h0000_0000);
	endtask : rd

	task automatic irq_is(input logic e);
		repeat (3) @(posedge clk);
		chk("irq", {31'h0000_0000, e}, {31'h0000_0000, irq});
	endtask : irq_is

	// Read results are judged against the oldest note at the ack edge
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) chk("rdata", expq.pop_front(), rdat);
	end

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#100000;
		n_mismatch++;
		stop_test();
	end

	initial begin : main
		{rst_n, cyc, stb, we, bal, st, adr, sel, dat} = '0;
		void'($urandom(32'h0000_217f));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(adr_ana, 32'h0000_0000);
		rd(adr_lnk, 32'h0000_0000);
		rd(adr_ist, 32'h0000_0000);
		$display("test reset done");
		i_lfs_link_model.frame(4'b0001);
		rd(adr_lnk, 32'h0000_0101);
		i_lfs_link_model.frame(4'b0010);
		rd(adr_lnk, 32'h0000_0203);
		i_lfs_link_model.frame(4'b0011);
		i_lfs_link_model.frame(4'b1100);
		rd(adr_lnk, 32'h0000_031b);
		wb(1'b1, adr_lnk, 4'h3, 32'h0000_00e0);
		rd(adr_lnk, 32'h0000_031b);
		wb(1'b1, adr_lnk, 4'h1, 32'h0000_ff1f);
		rd(adr_lnk, 32'h0000_0300);
		wb(1'b1, adr_lnk, 4'h2, 32'h0000_0100);
		rd(adr_lnk, 32'h0000_0000);
		// Clear of tally and flags lands on the very edge at which all four errors are taken
		fork
			i_lfs_link_model.frame(4'b1111);
			begin
				repeat (4) @(posedge clk);
				wb(1'b1, adr_lnk, 4'h3, 32'h0000_011f);
			end
		join
		rd(adr_lnk, 32'h0000_011b);
		wb(1'b1, adr_lnk, 4'h3, 32'h0000_ff1f);
		rd(adr_lnk, 32'h0000_0000);
		$display("test link flags done");
		m = 32'h0000_0000;
		for (int i = 0; i < 256; i++) begin
			k = ($urandom % 2) ? 4'b0001 : 4'b0010;
			m = m | {28'h000_0000, k};
			i_lfs_link_model.frame(k);
			if (i == 253) rd(adr_lnk, 32'h0000_fe00 | m);
			if (i >= 254) rd(adr_lnk, 32'h0000_ff04 | m);
		end
		$display("test saturation done");
		wb(1'b1, adr_ien, 4'h1, 32'h0000_0020);
		@(posedge clk);
		bal <= 1'b1;
		st  <= 1'b1;
		@(posedge clk);
		bal <= 1'b0;
		irq_is(1'b1);
		rd(adr_ana, 32'h0000_0003);
		wb(1'b1, adr_ana, 4'h1, 32'h0000_0001);
		rd(adr_ana, 32'h0000_0003);
		st <= 1'b0;
		wb(1'b1, adr_ana, 4'h3, 32'h0000_fffe);
		rd(adr_ana, 32'h0000_0001);
		wb(1'b1, adr_ana, 4'h1, 32'h0000_0001);
		rd(adr_ana, 32'h0000_0000);
		rd(adr_ist, 32'h0000_007f);
		wb(1'b1, adr_ien, 4'h1, 32'h0000_0000);
		irq_is(1'b0);
		wb(1'b1, adr_ien, 4'h1, 32'h0000_0040);
		irq_is(1'b1);
		wb(1'b1, adr_icl, 4'h1, 32'h0000_007f);
		irq_is(1'b0);
		rd(adr_ist, 32'h0000_0000);
		rd(adr_icl, 32'h0000_0000);
		rd(adr_ien, 32'h0000_0040);
		wb(1'b1, adr_nul, 4'hf, 32'hffff_ffff);
		rd(adr_nul, 32'h0000_0000);
		$display("test analog and irq done");
		repeat (4) @(posedge clk);
		stop_test();
	end
endmodule : test_lfs_top
